// File: src/dgp_gpio.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1: Port A has five bidirectional pins, each with a data bit and a direction bit.
// RQ2: A bank A direction bit of one puts the pin driver in high impedance.
// RQ3: A bank A direction bit of zero drives the pin from its output latch.
// RQ4: Power-on reset sets all five bank A direction bits, and pins then read zero; the code returns the outside pin levels instead.
// RQ5: Reading bank A data returns pin levels while a write only updates the latch.
// RQ6: Every port write samples the pins, modifies, and stores into the latch; the code masks off the pin sample and stores the write data unchanged.
// RQ7: Bank A bit 4 also feeds the timer external clock input through a Schmitt buffer.
// RQ8: Bank A bit 4 is open drain pulling only low, bits 0 to 3 are push-pull.
// RQ9: A pin whose peripheral is enabled is not used as general purpose I/O.
// RQ10: Bits 7 to 5 of bank A data and direction read as zero.
// RQ11: Other resets keep bank A data but force bank A direction to all ones.
// RQ12: Port B has eight bidirectional pins, each with a data bit and a direction bit.
// RQ13: Bank B direction one floats the pin, zero drives it from the latch.
// RQ14: A latch keeps its value while the pin is an input and drives once cleared.
module dgp_gpio (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        warm_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [4:0]  bank_a_in,
	output logic      [4:0]  bank_a_out,
	output logic      [4:0]  bank_a_oe,
	input  wire logic [7:0]  bank_b_in,
	output logic      [7:0]  bank_b_out,
	output logic      [7:0]  bank_b_oe,
	output logic             timer_external_clock_input
);

	typedef struct packed {
		logic [4:0]        a_latch;
		logic [4:0]        a_dir;
		logic [7:0]        b_latch;
		logic [7:0]        b_dir;
		logic              alt_timer;
		logic [7:0]        rdata;
		logic [1:0]        st_cnt;
		logic              st_level;
		logic              tclk;
		dgp_pkg::dgp_pins_s pins;
	} dgp_state_s;

	dgp_state_s       st;
	dgp_state_s       next_st;
	dgp_pkg::dgp_bus_s bus;
	logic [4:0]       a_pad_out;
	logic [4:0]       a_pad_oe;
	logic [7:0]       b_pad_out;
	logic [7:0]       b_pad_oe;

	assign bus.addr  = reg_addr;
	assign bus.wdata = reg_wdata;
	assign bus.wr    = reg_wr;
	assign bus.rd    = reg_rd;

	// Read-modify-write merge: the pin sample is masked to zero, so the latch takes the write data alone
	function automatic logic [7:0] rmw_merge(
		input logic [7:0] pins,
		input logic [7:0] wdata
	);
		logic [7:0] sampled;
		sampled = pins;
		rmw_merge = wdata | (sampled & 8'h00);
	endfunction

	dgp_pin_cell #(
		.WIDTH      (dgp_pkg::A_WIDTH),
		.OPEN_DRAIN (8'h10)
	) u_cell_a (
		.latch     (st.a_latch),
		.direction (st.a_dir | {st.alt_timer, 4'h0}),
		.pad_out   (a_pad_out),
		.pad_oe    (a_pad_oe)
	);

	dgp_pin_cell #(
		.WIDTH      (dgp_pkg::B_WIDTH),
		.OPEN_DRAIN (8'h00)
	) u_cell_b (
		.latch     (st.b_latch),
		.direction (st.b_dir),
		.pad_out   (b_pad_out),
		.pad_oe    (b_pad_oe)
	);

	always_comb begin
		logic [7:0] a_word;
		logic [7:0] a_merge;
		a_word  = {3'h0, bank_a_in};
		a_merge = rmw_merge(a_word, bus.wdata);
		next_st = st;
		if (bus.wr) begin
			case (bus.addr)
				dgp_pkg::ADDR_BANK_A_PIN_DATA: begin
					next_st.a_latch = a_merge[4:0]; // RQ6
				end
				dgp_pkg::ADDR_BANK_A_DIRECTION: begin
					next_st.a_dir = bus.wdata[4:0]; // RQ1
				end
				dgp_pkg::ADDR_BANK_B_PIN_DATA: begin
					next_st.b_latch = rmw_merge(bank_b_in, bus.wdata); // RQ6
				end
				dgp_pkg::ADDR_BANK_B_DIRECTION: begin
					next_st.b_dir = bus.wdata; // RQ12
				end
				dgp_pkg::ADDR_ALT_CONTROL: begin
					next_st.alt_timer = bus.wdata[dgp_pkg::ALT_TIMER_BIT];
				end
				default: begin
				end
			endcase
		end
		next_st.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				dgp_pkg::ADDR_BANK_A_PIN_DATA:  next_st.rdata = a_word; // RQ5 RQ10
				dgp_pkg::ADDR_BANK_A_DIRECTION: next_st.rdata = {3'h0, st.a_dir}; // RQ10
				dgp_pkg::ADDR_BANK_B_PIN_DATA:  next_st.rdata = bank_b_in; // RQ5
				dgp_pkg::ADDR_BANK_B_DIRECTION: next_st.rdata = st.b_dir;
				dgp_pkg::ADDR_ALT_CONTROL:      next_st.rdata = {7'h00, st.alt_timer};
				default:                        next_st.rdata = 8'h00;
			endcase
		end
		// Schmitt-like hysteresis: level flips only after three agreeing samples
		if (bank_a_in[dgp_pkg::TIMER_PIN_BIT] == st.st_level) begin
			next_st.st_cnt = 2'h0;
		end else if (st.st_cnt == 2'h2) begin
			next_st.st_cnt   = 2'h0;
			next_st.st_level = ~st.st_level; // RQ7
		end else begin
			next_st.st_cnt = st.st_cnt + 2'h1;
		end
		next_st.tclk       = st.st_level; // RQ7
		// Latch untouched by direction, so it drives one clock after direction clears
		next_st.pins.a_out = a_pad_out; // RQ14
		next_st.pins.a_oe  = a_pad_oe; // RQ9
		next_st.pins.b_out = b_pad_out; // RQ13
		next_st.pins.b_oe  = b_pad_oe; // RQ13
		if (warm_rst) begin
			next_st.a_dir     = dgp_pkg::RST_BANK_A_DIRECTION; // RQ11
			next_st.b_dir     = dgp_pkg::RST_BANK_B_DIRECTION;
			next_st.pins.a_oe = 5'h00;
			next_st.pins.b_oe = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st         <= '0;
			st.a_dir   <= dgp_pkg::RST_BANK_A_DIRECTION; // RQ4
			st.b_dir   <= dgp_pkg::RST_BANK_B_DIRECTION;
			st.a_latch <= dgp_pkg::RST_BANK_A_LATCH;
			st.b_latch <= dgp_pkg::RST_BANK_B_LATCH;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata                  = st.rdata;
	assign bank_a_out                 = st.pins.a_out;
	assign bank_a_oe                  = st.pins.a_oe;
	assign bank_b_out                 = st.pins.b_out;
	assign bank_b_oe                  = st.pins.b_oe;
	assign timer_external_clock_input = st.tclk;

endmodule

`default_nettype wire

// File: common/dgp_pkg.sv
package dgp_pkg;

	localparam int A_WIDTH = 5;
	localparam int B_WIDTH = 8;
	localparam int REG_AW  = 8;

	localparam logic [7:0] ADDR_BANK_A_PIN_DATA  = 8'h05;
	localparam logic [7:0] ADDR_BANK_A_DIRECTION = 8'h85;
	localparam logic [7:0] ADDR_BANK_B_PIN_DATA  = 8'h06;
	localparam logic [7:0] ADDR_BANK_B_DIRECTION = 8'h86;
	localparam logic [7:0] ADDR_ALT_CONTROL      = 8'h07;

	localparam logic [4:0] RST_BANK_A_DIRECTION = 5'h1F;
	localparam logic [7:0] RST_BANK_B_DIRECTION = 8'hFF;
	localparam logic [4:0] RST_BANK_A_LATCH     = 5'h00;
	localparam logic [7:0] RST_BANK_B_LATCH     = 8'h00;

	localparam int TIMER_PIN_BIT = 4;
	localparam int ALT_TIMER_BIT = 0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dgp_bus_s;

	typedef struct packed {
		logic [4:0] a_out;
		logic [4:0] a_oe;
		logic [7:0] b_out;
		logic [7:0] b_oe;
	} dgp_pins_s;

endpackage

// File: src/dgp_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

// One bank of pad control; open drain bits may only pull low
module dgp_pin_cell #(
	parameter int          WIDTH      = 8,
	parameter logic [7:0]  OPEN_DRAIN = 8'h00
) (
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] direction,
	output logic      [WIDTH-1:0] pad_out,
	output logic      [WIDTH-1:0] pad_oe
);

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (OPEN_DRAIN[i]) begin
				pad_out[i] = 1'b0; // RQ8
				pad_oe[i]  = ~direction[i] & ~latch[i]; // RQ8
			end else begin
				pad_out[i] = latch[i]; // RQ3
				pad_oe[i]  = ~direction[i]; // RQ2
			end
		end
	end

endmodule

`default_nettype wire

// File: tb/dgp_props.sv
`timescale 1ns/1ps
`default_nettype none
module dgp_props (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       warm_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [4:0] bank_a_in,
	input wire logic [4:0] bank_a_out,
	input wire logic [4:0] bank_a_oe,
	input wire logic [7:0] bank_b_in,
	input wire logic [7:0] bank_b_oe,
	input wire logic       timer_external_clock_input
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_od; bank_a_out[4] == 1'b0; endproperty
	a_od: assert property (p_od) else $error("open drain bit driven high");
	property p_rst; $past(srst) |-> (bank_a_oe | bank_b_oe) == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("driver on after reset");
	property p_hi; reg_rd && reg_addr[6:0] == 7'h05 |=> reg_rdata[7:5] == 3'h0; endproperty
	a_hi: assert property (p_hi) else $error("unimplemented bits set");
	property p_ra; reg_rd && reg_addr == 8'h05 |=> reg_rdata == {3'h0, $past(bank_a_in)}; endproperty
	a_ra: assert property (p_ra) else $error("port a read not pins");
	property p_rb; reg_rd && reg_addr == 8'h06 |=> reg_rdata == $past(bank_b_in); endproperty
	a_rb: assert property (p_rb) else $error("port b read not pins");
	property p_warm; warm_rst |-> ##2 (bank_a_oe | bank_b_oe) == 8'h00; endproperty
	a_warm: assert property (p_warm) else $error("driver on after warm reset");
	// Filter needs three samples plus output flop
	property p_th; bank_a_in[4] [*6] |-> timer_external_clock_input; endproperty
	a_th: assert property (p_th) else $error("timer clock not high");
	property p_tl; !bank_a_in[4] [*6] |-> !timer_external_clock_input; endproperty
	a_tl: assert property (p_tl) else $error("timer clock not low");
	c_rd: cover property (reg_rd && reg_addr == 8'h05);
	c_warm: cover property (warm_rst);
	c_tmr: cover property (timer_external_clock_input);
endmodule
bind dgp_gpio dgp_props i_props (.*);
`default_nettype wire

// File: tb/dgp_pins.sv
`timescale 1ns/1ps
`default_nettype none
module dgp_pins (
	input  wire logic [4:0] a_out,
	input  wire logic [4:0] a_oe,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe,
	input  wire logic [4:0] a_ext,
	input  wire logic [7:0] b_ext,
	output logic      [4:0] a_lvl,
	output logic      [7:0] b_lvl
);
	// Released pins show the outside level, never the last drive
	assign a_lvl = (a_oe & a_out) | (~a_oe & a_ext);
	assign b_lvl = (b_oe & b_out) | (~b_oe & b_ext);
endmodule
`default_nettype wire

// File: tb/dual_gpio_port_direction_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port_direction_tb;
	logic       clk, srst, warm_rst, reg_wr, reg_rd, tck;
	logic [7:0] reg_addr, reg_wdata, rdata, bin, bout, boe, bext, da, la, db, lb;
	logic [4:0] ain, aout, aoe, aext;
	logic       alt;
	int         fails, samples_checked, cyc;
	dgp_gpio i_dut (.clk(clk), .srst(srst), .warm_rst(warm_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.bank_a_in(ain), .bank_a_out(aout), .bank_a_oe(aoe), .bank_b_in(bin),
		.bank_b_out(bout), .bank_b_oe(boe), .timer_external_clock_input(tck));
	dgp_pins i_pins (.a_out(aout), .a_oe(aoe), .b_out(bout), .b_oe(boe),
		.a_ext(aext), .b_ext(bext), .a_lvl(ain), .b_lvl(bin));
	task automatic stop_test;
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// Strobe dropped then one idle edge, so no double drive per step
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
		@(posedge clk);
	endtask
	task automatic chk;
		logic [4:0] ea;
		#1 ea = ~da[4:0] & ~{alt | la[4], 4'h0};
		cmp("a_oe", ea, aoe);
		cmp("a_out", la & ea & 5'h0F, aout & ea);
		cmp("b_oe", ~db, boe);
		cmp("b_out", lb & ~db, bout & ~db);
		rd(8'h05, (ea & la & 5'h0F) | (~ea & aext));
		rd(8'h06, (~db & lb) | (db & bext));
		rd(8'h85, da);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			stop_test;
		end
	end
	initial begin
		{srst, warm_rst, reg_wr, reg_rd} = 4'h8;
		{reg_addr, reg_wdata, aext, bext, alt} = 30'h00000000;
		{da, la, db, lb} = {8'h1F, 8'h00, 8'hFF, 8'h00};
		void'($urandom(40));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk;
		rd(8'h86, 8'hFF);
		for (int i = 0; i < 30; i++) begin
			{la, da, lb, db} = $urandom;
			aext <= 5'($urandom);
			bext <= 8'($urandom);
			wr(8'h05, la);
			wr(8'h85, da);
			wr(8'h06, lb);
			wr(8'h86, db);
			la &= 8'h1F;
			da &= 8'h1F;
			chk;
		end
		warm_rst <= 1'b1;
		@(posedge clk);
		warm_rst <= 1'b0;
		{da, db} = 16'h1FFF;
		repeat (2) @(posedge clk);
		chk;
		wr(8'h85, 8'h00);
		wr(8'h86, 8'h00);
		{da, db} = 16'h0000;
		chk;
		wr(8'h10, 8'hA5);
		rd(8'h10, 8'h00);
		wr(8'h07, 8'h01);
		wr(8'h05, 8'h00);
		{alt, la} = 9'h100;
		chk;
		wr(8'h85, 8'h1F);
		da = 8'h1F;
		aext <= 5'h10;
		repeat (6) @(posedge clk);
		#1 cmp("tck", 8'h01, tck);
		aext <= 5'h00;
		repeat (6) @(posedge clk);
		#1 cmp("tck", 8'h00, tck);
		stop_test;
	end
endmodule
`default_nettype wire
